// >>> core/tw_ctrl_top.sv
// two-wire control, status and own-address block with its bus-facing logic
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module tw_ctrl_top #(
  parameter int ADDR_W = tw_pkg::AXI_AW
) (
  // system clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // timer overflow pulse, same clock
  input wire logic timer_ovf,
  // link clock and open-drain bus pins
  input wire logic link_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe
);
  import tw_pkg::*;

  if (ADDR_W != AXI_AW) begin : g_chk
    $error("tw_ctrl_top: ADDR_W must equal the package address width");
  end

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001, M_START = 4'b0010, M_OWN = 4'b0100, M_STOP = 4'b1000
  } tw_mst_t;
  typedef enum logic [3:0] {
    L_IDLE = 4'b0001, L_ADDR = 4'b0010, L_ACK = 4'b0100, L_HELD = 4'b1000
  } tw_lnk_t;

  // ==================================================
  // axi4-lite write path
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wdat_q, wdat_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;
  tw_sel_t wr_sel;

  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign wr_sel = tw_reg_sel(awaddr_q);

  // address and data taken in either order, answered once both are in
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdat_d = wdat_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    wr_fire = 1'b0;
    if (awvalid && awready) begin
      aw_have_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_have_d = 1'b1;
      wdat_d = wdata[7:0];
      wlane_d = wstrb[0]; // upper lanes hold nothing
    end
    if (aw_have_q && w_have_q) begin
      wr_fire = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (wr_sel == SEL_NONE) ? AXI_SLVERR : AXI_OKAY;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdat_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdat_q <= wdat_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // ==================================================
  // control, own address, event flag and event code
  logic [7:0] ctrl_q, ctrl_d, addr_q, addr_d, code_q, code_d;
  logic [7:0] pend_q, pend_d;
  logic flag_q, flag_d, load_q, load_d;
  logic wr_ctrl, wr_addr, hw_set, ev_edge, start_done, stop_done;
  logic [7:0] ev_code_lq;
  logic [7:0] ctrl_view;

  assign wr_ctrl = wr_fire && wlane_q && (wr_sel == SEL_CTRL);
  assign wr_addr = wr_fire && wlane_q && (wr_sel == SEL_ADDR);
  assign hw_set = ev_edge || start_done;

  // hardware set of the flag wins over a software clear in the same cycle
  always_comb begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    flag_d = flag_q;
    pend_d = pend_q;
    load_d = hw_set;
    if (stop_done) begin
      ctrl_d[F_STOP] = 1'b0;
    end
    if (wr_ctrl) begin
      ctrl_d = wdat_q;
      ctrl_d[F_FLAG] = 1'b0;
      if (!wdat_q[F_FLAG]) begin
        flag_d = 1'b0; // writing one leaves the flag alone
      end
    end
    if (wr_addr) begin
      addr_d = wdat_q;
    end
    if (hw_set) begin
      flag_d = 1'b1;
      pend_d = ev_edge ? ev_code_lq : EV_START;
    end
    // code follows the flag one cycle late
    if (load_q) begin
      code_d = pend_q;
    end else if (flag_q) begin
      code_d = code_q;
    end else begin
      code_d = CODE_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      addr_q <= ADDR_RST;
      code_q <= CODE_IDLE;
      pend_q <= CODE_IDLE;
      flag_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      code_q <= code_d;
      pend_q <= pend_d;
      flag_q <= flag_d;
      load_q <= load_d;
    end
  end

  always_comb begin
    ctrl_view = ctrl_q;
    ctrl_view[F_FLAG] = flag_q;
  end

  // ==================================================
  // axi4-lite read path
  logic rvalid_q, rvalid_d;
  logic [7:0] rdat_q, rdat_d;
  logic [1:0] rresp_q, rresp_d;

  assign arready = !rvalid_q;

  // one read in flight; unmapped words read zero with an error
  always_comb begin
    rvalid_d = rvalid_q;
    rdat_d = rdat_q;
    rresp_d = rresp_q;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d = AXI_OKAY;
      unique case (tw_reg_sel(araddr))
        SEL_CTRL: rdat_d = ctrl_view;
        SEL_CODE: rdat_d = code_q;
        SEL_ADDR: rdat_d = addr_q;
        SEL_NONE: begin
          rdat_d = 8'h00;
          rresp_d = AXI_SLVERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdat_q <= 8'h00;
      rresp_q <= AXI_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdat_q <= rdat_d;
      rresp_q <= rresp_d;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = {24'h000000, rdat_q};
  assign rresp = rresp_q;

  // ==================================================
  // master start and stop sequencer
  tw_rate_if rate_if ();
  tw_mst_t mst_q, mst_d;
  logic busy_s, ev_tgl_s, ev_tgl_p_q;
  logic m_sda_low, m_scl_low;

  // rate bits taken together pick the master clock
  assign rate_if.code = {ctrl_q[F_RATE_HI], ctrl_q[F_RATE_MID], ctrl_q[F_RATE_LO]};
  assign rate_if.run = ctrl_q[F_IFACE_EN];
  assign rate_if.ovf = timer_ovf;

  tw_rate_gen u_rate (
    .aclk(aclk),
    .aresetn(aresetn),
    .rate(rate_if)
  );

  // start may only begin on a free bus; repeated start is not generated here
  always_comb begin
    mst_d = mst_q;
    start_done = 1'b0;
    stop_done = 1'b0;
    unique case (mst_q)
      M_IDLE: begin
        if (ctrl_q[F_STOP]) begin
          stop_done = 1'b1; // not master: nothing to send
        end else if (ctrl_q[F_START] && !busy_s && !flag_q && rate_if.tick) begin
          mst_d = M_START;
        end
      end
      M_START: begin
        if (rate_if.tick) begin
          mst_d = M_OWN;
          start_done = 1'b1;
        end
      end
      M_OWN: begin
        if (ctrl_q[F_STOP] && !flag_q && rate_if.tick) begin
          mst_d = M_STOP;
        end
      end
      M_STOP: begin
        if (rate_if.tick) begin
          mst_d = M_IDLE;
          stop_done = 1'b1;
        end
      end
    endcase
    if (!ctrl_q[F_IFACE_EN]) begin
      mst_d = M_IDLE;
      start_done = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mst_q <= M_IDLE;
      ev_tgl_p_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      ev_tgl_p_q <= ev_tgl_s;
    end
  end

  // single state bits: the link side synchronises them, so no decode glitch may cross
  assign m_sda_low = !mst_q[0];
  assign m_scl_low = mst_q[2];
  assign ev_edge = ev_tgl_s ^ ev_tgl_p_q;

  // ==================================================
  // link clock domain: pins, address match, acknowledge
  logic link_rst_n;
  logic sda_s, scl_s;
  logic [7:0] own_s;
  logic ack_s, en_s, flag_s, mscl_s, msda_s;
  tw_lnk_t ls_q, ls_d;
  logic sda_p_q, scl_p_q, busy_lq, busy_ld, ev_tgl_lq, ev_tgl_ld;
  logic [7:0] shift_q, shift_d, ev_code_ld;
  logic [3:0] cnt_q, cnt_d;
  logic sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
  logic start_c, stop_c, scl_rise, scl_fall, own_hit, gc_hit;

  tw_sync #(.W(1), .RST_VAL(1'b0)) u_lrst (
    .clk(link_clk),
    .rst_n(1'b1),
    .d(aresetn),
    .q(link_rst_n)
  );

  // config is quasi-static: change it only with the interface idle
  tw_sync #(.W(2), .RST_VAL(1'b1)) u_pins (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({sda_i, scl_i}),
    .q({sda_s, scl_s})
  );

  tw_sync #(.W(13), .RST_VAL(1'b0)) u_cfg (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({addr_q, ctrl_q[F_ACK], ctrl_q[F_IFACE_EN], flag_q, m_scl_low, m_sda_low}),
    .q({own_s, ack_s, en_s, flag_s, mscl_s, msda_s})
  );

  tw_sync #(.W(2), .RST_VAL(1'b0)) u_back (
    .clk(aclk),
    .rst_n(aresetn),
    .d({busy_lq, ev_tgl_lq}),
    .q({busy_s, ev_tgl_s})
  );

  assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  // 00h counts only with general call on; else it is nobody's address
  assign gc_hit = (shift_q[7:1] == GC_ADDR) && own_s[0];
  assign own_hit = (shift_q[7:1] == own_s[7:1]) && (shift_q[7:1] != GC_ADDR);

  // receive the address byte, acknowledge a match, report events
  always_comb begin
    ls_d = ls_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    ev_tgl_ld = ev_tgl_lq;
    ev_code_ld = ev_code_lq;
    busy_ld = busy_lq;
    if (start_c) busy_ld = 1'b1;
    if (stop_c) busy_ld = 1'b0;
    unique case (ls_q)
      L_IDLE: begin
        if (start_c) begin
          ls_d = L_ADDR;
          cnt_d = 4'h0;
        end
      end
      L_ADDR: begin
        if (stop_c) begin
          ls_d = L_IDLE;
        end else if (start_c) begin
          cnt_d = 4'h0;
        end else if (scl_rise && cnt_q < 4'(BITS_PER_ADDR)) begin
          shift_d = {shift_q[6:0], sda_s};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == 4'(BITS_PER_ADDR)) begin
          if ((gc_hit || own_hit) && ack_s) begin
            ls_d = L_ACK;
            ev_code_ld = gc_hit ? EV_GCALL : (shift_q[0] ? EV_SLA_R : EV_SLA_W);
          end else begin
            ls_d = L_IDLE;
          end
        end
      end
      L_ACK: begin
        if (scl_fall) begin
          ls_d = L_HELD;
          ev_tgl_ld = !ev_tgl_lq;
        end
      end
      L_HELD: begin
        if (stop_c || start_c) begin
          ls_d = start_c ? L_ADDR : L_IDLE;
          cnt_d = 4'h0;
          ev_code_ld = EV_STOP_SL;
          ev_tgl_ld = !ev_tgl_lq;
        end
      end
    endcase
    if (!en_s) begin
      ls_d = L_IDLE;
    end
    scl_oe_d = flag_s || mscl_s;
    sda_oe_d = (ls_q == L_ACK) || msda_s;
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ls_q <= L_IDLE;
      sda_p_q <= 1'b1;
      scl_p_q <= 1'b1;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      busy_lq <= 1'b0;
      ev_tgl_lq <= 1'b0;
      ev_code_lq <= CODE_IDLE;
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      ls_q <= ls_d;
      sda_p_q <= sda_s;
      scl_p_q <= scl_s;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      busy_lq <= busy_ld;
      ev_tgl_lq <= ev_tgl_ld;
      ev_code_lq <= ev_code_ld;
      sda_oe_q <= sda_oe_d;
      scl_oe_q <= scl_oe_d;
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = sda_oe_q;
  assign scl_oe = scl_oe_q;
endmodule : tw_ctrl_top

// >>> core/tw_rate_gen.sv
// master bit-rate generator: one tick per half bit period
`timescale 1ns/1ps
module tw_rate_gen (
  // system clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // rate request and tick
  tw_rate_if.gen rate
);
  import tw_pkg::*;

  logic [7:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [7:0] lim;
  logic step;

  // count clocks, or timer overflows in timer mode
  always_comb begin
    lim = tw_half_count(rate.code);
    step = (rate.code == RATE_TMR) ? rate.ovf : 1'b1;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!rate.run || lim == 8'h00) begin
      cnt_d = 8'h00; // unused code gives no clock
    end else if (step) begin
      if (cnt_q >= lim - 8'h01) begin
        cnt_d = 8'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign rate.tick = tick_q;
endmodule : tw_rate_gen

// >>> core/tw_sync.sv
// two flip-flop synchroniser for quasi-static levels
`timescale 1ns/1ps
module tw_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and synchronous reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= {W{RST_VAL}};
      s2_q <= {W{RST_VAL}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule : tw_sync

// >>> dv/tb_top.sv
// self-checking bench of the two-wire control block
`timescale 1ns/1ps
module tb_top;
  import tw_pkg::*;
  // ========
  // signals
  logic aclk = 1'b0;
  logic link_clk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic timer_ovf = 1'b0;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, sda_i, sda_o, sda_oe, scl_i, scl_o, scl_oe;
  logic [1:0] bresp, rresp, last_b, rr;
  logic [31:0] rdata, rw;
  logic [7:0] ctl_v;
  logic ack;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [11:0] A_CTRL = 12'({CTRL_IDX, 2'b00});
  localparam logic [11:0] A_CODE = 12'({CODE_IDX, 2'b00});
  localparam logic [11:0] A_ADDR = 12'({ADDR_IDX, 2'b00});
  // ========
  // clocks, timer pulses, design and partner
  initial forever #12.5 aclk = ~aclk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  // one timer overflow every 4 cycles, so code 111 gives a 192-cycle half bit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    timer_ovf <= (cyc % 4 == 0);
  end
  tw_ctrl_top #(.ADDR_W(12)) u_dut (.*);
  tw_bus_model u_bus (.link_clk(link_clk), .sda_oe(sda_oe), .scl_oe(scl_oe), .sda(sda_i),
    .scl(scl_i));
  // ========
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    last_b = bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    rw = rdata;
    rr = rresp;
  endtask : rd
  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp);
    rd(a);
    chk(what, {24'h0, exp}, rw);
  endtask : rchk
  // flagged event: code shown, clock held, then freed once software clears the flag
  task automatic ev_check(input logic [7:0] code);
    idle(40);
    rd(A_CTRL);
    chk("event flag", 32'h1, {31'h0, rw[3]});
    rchk("event code", A_CODE, code);
    chk("scl held", 32'h1, {31'h0, scl_oe});
    wr(A_CTRL, ctl_v);
    idle(40);
    chk("scl freed", 32'h0, {31'h0, scl_oe});
    rchk("idle code", A_CODE, 8'hf8);
  endtask : ev_check
  // ========
  // scenarios
  task automatic t_regs();
    rchk("control reset", A_CTRL, 8'h00);
    rchk("code reset", A_CODE, 8'hf8);
    rchk("address reset", A_ADDR, 8'hfe);
    rd(12'h000);
    chk("unmapped read", {30'h0, AXI_SLVERR}, {30'h0, rr});
    wr(A_CODE, 8'h55);
    chk("read-only write", 32'h0, {30'h0, last_b});
    rchk("code kept", A_CODE, 8'hf8);
    wr(12'h004, 8'h55);
    chk("unmapped write", {30'h0, AXI_SLVERR}, {30'h0, last_b});
    $display("test regs done");
  endtask : t_regs
  task automatic t_slave();
    logic [7:0] sla [3] = '{8'h84, 8'h85, 8'h00};
    logic [7:0] evc [3] = '{8'h60, 8'ha8, 8'h70};
    ctl_v = 8'h44;
    wr(A_CTRL, ctl_v);
    wr(A_ADDR, 8'h84);
    u_bus.send_addr(8'h86, ack);
    chk("foreign address", 32'h1, {31'h0, ack});
    u_bus.send_stop();
    u_bus.send_addr(8'h00, ack);
    chk("call ignored", 32'h1, {31'h0, ack});
    u_bus.send_stop();
    rchk("no event", A_CTRL, ctl_v);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) wr(A_ADDR, 8'h85);
      u_bus.send_addr(sla[i], ack);
      chk("address acked", 32'h0, {31'h0, ack});
      ev_check(evc[i]);
      u_bus.send_stop();
      ev_check(8'ha0);
    end
    $display("test slave done");
  endtask : t_slave
  task automatic t_master();
    int half [8] = '{128, 112, 96, 80, 0, 60, 30, 192};
    int t0;
    logic [7:0] c;
    for (int k = 0; k < 8; k++) begin
      c = {k[2], 5'b11000, k[1:0]};
      wr(A_CTRL, c);
      t0 = cyc;
      rw = '0;
      while (rw[3] !== 1'b1 && cyc - t0 < 700) rd(A_CTRL);
      if (k == 4) begin
        chk("unused rate stalls", 32'h0, {31'h0, rw[3]});
        wr(A_CTRL, 8'h00);
      end else begin
        t0 = cyc - t0 - half[k]; // time beyond one half bit
        chk("start time", 32'h1, {31'h0, t0 >= -4 && t0 <= half[k] + 40});
        chk("start kept", 32'h1, {31'h0, rw[5]});
        rchk("start code", A_CODE, 8'h08);
        wr(A_CTRL, c ^ 8'h30);
        idle(3 * half[k] + 80);
        rd(A_CTRL);
        chk("stop cleared", 32'h0, {31'h0, rw[4]});
        chk("lines free", 32'h0, {30'h0, sda_oe, scl_oe});
      end
    end
    $display("test master done");
  endtask : t_master
  // ========
  // verdict, main sequence and watchdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // reset spans several link clocks so the link side sees it too
  initial begin
    repeat (32) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_slave();
    t_master();
    wrap_up();
  end
  initial begin
    #1_500_000;
    fails++;
    $display("ERROR watchdog expected end seen hang");
    wrap_up();
  end
endmodule : tb_top

// >>> dv/tw_bus_model.sv
// far side of the bus: a two-wire master that addresses the block
`timescale 1ns/1ps
module tw_bus_model (
  // link clock
  input wire logic link_clk,
  // pulls from the block
  input wire logic sda_oe,
  input wire logic scl_oe,
  // resolved line levels
  output logic sda,
  output logic scl
);
  logic sda_pull = 1'b0;
  logic scl_pull = 1'b0;
  // lines have pull-ups, so a released line reads high
  assign sda = !(sda_pull || sda_oe);
  assign scl = !(scl_pull || scl_oe);
  // wait n link clocks
  task automatic step(input int n);
    repeat (n) @(posedge link_clk);
  endtask : step
  // start, address byte msb first, ninth clock; ack_lvl low means acked
  task automatic send_addr(input logic [7:0] a, output logic ack_lvl);
    sda_pull <= 1'b1;
    step(8);
    for (int i = 7; i >= 0; i--) begin
      scl_pull <= 1'b1;
      step(2);
      sda_pull <= !a[i];
      step(6);
      scl_pull <= 1'b0;
      step(8);
    end
    scl_pull <= 1'b1;
    step(2);
    sda_pull <= 1'b0;
    step(6);
    scl_pull <= 1'b0;
    step(4);
    ack_lvl = sda;
    step(4);
    scl_pull <= 1'b1;
    step(2);
  endtask : send_addr
  // stop; waits while the block stretches the clock
  task automatic send_stop();
    sda_pull <= 1'b1;
    step(4);
    scl_pull <= 1'b0;
    for (int k = 0; k < 400 && !scl; k++) step(1);
    step(8);
    sda_pull <= 1'b0;
    step(8);
  endtask : send_stop
endmodule : tw_bus_model

// >>> dv/tw_ctrl_props.sv
// port checks of the two-wire control block
`timescale 1ns/1ps
module tw_ctrl_props
  import tw_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // bus pins
  input wire logic sda_o,
  input wire logic scl_o,
  input wire logic scl_oe
);
  // ========
  // helpers
  localparam logic [ADDR_W-1:0] A_CTRL = ADDR_W'({CTRL_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_CODE = ADDR_W'({CODE_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] A_ADDR = ADDR_W'({ADDR_IDX, 2'b00});
  logic [ADDR_W-1:0] ar_q;
  logic mapped;
  assign mapped = araddr inside {A_CTRL, A_CODE, A_ADDR};
  // last read address, ties an answer to its register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_q <= '0;
    end else if (arvalid && arready) begin
      ar_q <= araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========
  // assertions
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response changed before bready");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before rready");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("no write response two cycles after address and data");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read answer one cycle after the address");
  a_read_refuse: assert property (rvalid |-> !arready)
    else $error("read address taken while an answer stands");
  a_write_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while a response stands");
  a_bad_read: assert property (arvalid && arready && !mapped
    |=> rresp == AXI_SLVERR && rdata == '0)
    else $error("unmapped read not refused");
  a_good_read: assert property (arvalid && arready && mapped
    |=> rresp == AXI_OKAY && rdata[31:8] == '0)
    else $error("mapped read answer wrong");
  a_code_low: assert property (rvalid && ar_q == A_CODE |-> rdata[2:0] == 3'h0)
    else $error("event code low bits not zero");
  a_open_drain: assert property (sda_o == 1'b0 && scl_o == 1'b0)
    else $error("bus pin driven high");
  // main scenarios reached
  c_bad_write: cover property (bvalid && bresp == AXI_SLVERR);
  c_code_read: cover property (arvalid && arready && araddr == A_CODE);
  c_scl_held: cover property ($rose(scl_oe));
endmodule : tw_ctrl_props

bind tw_ctrl_top tw_ctrl_props #(.ADDR_W(ADDR_W)) u_props (.*);

// >>> shared/tw_pkg.sv
// constants, field layout and helper functions of the two-wire control block
//
// How it works
// - in master mode the bit rate comes from the three rate-select bits at control bits 7, 1, 0.
// - as a slave the block answers an address equal to own address bits 7..1, and 00h only with general call enabled.
// - general-call enable (address bit 0) adds recognition of address 00h; clear, 00h is ignored.
// - after reset the own-address register holds 8'hfe.
// - rate codes give divisions 256,224,192,160,120,60; code 100 is unused; 111 is 96 timer ovfs.
// - a bus event sets the event flag, and one cycle later the event code register is loaded.
// - while the event flag is set the serial clock line is held low.
// - without a flagged event the event code register reads the no-information code.
package tw_pkg;
  // ==================================================
  // register map (indices; byte address is four times)
  localparam int AXI_AW = 12;
  localparam logic [7:0] CTRL_IDX = 8'haa;
  localparam logic [7:0] CODE_IDX = 8'hab;
  localparam logic [7:0] ADDR_IDX = 8'hac;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ==================================================
  // control field positions
  localparam int F_RATE_HI = 7;
  localparam int F_IFACE_EN = 6;
  localparam int F_START = 5;
  localparam int F_STOP = 4;
  localparam int F_FLAG = 3;
  localparam int F_ACK = 2;
  localparam int F_RATE_MID = 1;
  localparam int F_RATE_LO = 0;
  // ==================================================
  // reset values and event codes
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'hfe;
  localparam logic [7:0] CODE_IDLE = 8'hf8;
  localparam logic [7:0] EV_START = 8'h08;
  localparam logic [7:0] EV_SLA_W = 8'h60;
  localparam logic [7:0] EV_GCALL = 8'h70;
  localparam logic [7:0] EV_SLA_R = 8'ha8;
  localparam logic [7:0] EV_STOP_SL = 8'ha0;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // ==================================================
  // rate divisions (whole bit periods) and timer mode
  localparam int DIV_0 = 256;
  localparam int DIV_1 = 224;
  localparam int DIV_2 = 192;
  localparam int DIV_3 = 160;
  localparam int DIV_5 = 120;
  localparam int DIV_6 = 60;
  localparam int DIV_TMR = 96;
  localparam logic [2:0] RATE_TMR = 3'h7;
  localparam int BITS_PER_ADDR = 8;

  typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_CODE, SEL_ADDR} tw_sel_t;

  // half bit period in counts; zero means no clock for this code
  function automatic logic [7:0] tw_half_count(input logic [2:0] code);
    unique case (code)
      3'h0: return 8'(DIV_0 / 2);
      3'h1: return 8'(DIV_1 / 2);
      3'h2: return 8'(DIV_2 / 2);
      3'h3: return 8'(DIV_3 / 2);
      3'h5: return 8'(DIV_5 / 2);
      3'h6: return 8'(DIV_6 / 2);
      3'h7: return 8'(DIV_TMR / 2);
      default: return 8'h00;
    endcase
  endfunction : tw_half_count

  // register decode, used by both the read and the write path
  function automatic tw_sel_t tw_reg_sel(input logic [AXI_AW-1:0] a);
    if (a == AXI_AW'({CTRL_IDX, 2'b00})) return SEL_CTRL;
    if (a == AXI_AW'({CODE_IDX, 2'b00})) return SEL_CODE;
    if (a == AXI_AW'({ADDR_IDX, 2'b00})) return SEL_ADDR;
    return SEL_NONE;
  endfunction : tw_reg_sel
endpackage : tw_pkg

// >>> shared/tw_rate_if.sv
// rate request and half-bit tick between the control block and its rate generator
`timescale 1ns/1ps
interface tw_rate_if;
  logic [2:0] code;
  logic run;
  logic ovf;
  logic tick;
  modport gen (input code, input run, input ovf, output tick);
  modport user (output code, output run, output ovf, input tick);
endinterface : tw_rate_if
